// [core/ppp_consts.svh]
// Constants for the parallel printer port: register offsets, fields, resets, timing.
// Assumes inclusion by the package, the port, the checker and the bench.
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH
`define PPP_OFF_DATA 8'h00
`define PPP_OFF_CTRL 8'h04
`define PPP_OFF_STAT 8'h08
`define PPP_OFF_IRQST 8'h0c
`define PPP_OFF_IRQMSK 8'h10
`define PPP_OFF_COND0 8'h14
`define PPP_OFF_COND1 8'h18
`define PPP_CTRL_DIR 0
`define PPP_CTRL_AUTO 1
`define PPP_CTRL_FAST 2
`define PPP_CTRL_STRB 3
`define PPP_CTRL_INIT 4
`define PPP_RST_CTRL 8'h02
`define PPP_RST_DATA 8'h00
`define PPP_RST_STAT 5'h02
`define PPP_RST_PINS 8'h00
`define PPP_CLK_MHZ 25
`define PPP_SLOW_NS 1000
`define PPP_FAST_NS 200
`define PPP_SLOW_CYC ((`PPP_SLOW_NS * `PPP_CLK_MHZ + 999) / 1000)
`define PPP_FAST_CYC ((`PPP_FAST_NS * `PPP_CLK_MHZ + 999) / 1000)
`endif

// [core/ppp_pkg.sv]
// Types for the parallel printer port.
// Assumes the constants header sits beside it.
`include "ppp_consts.svh"
package ppp_pkg;
  typedef enum logic [1:0] {
    PPP_HIGH,
    PPP_LOW,
    PPP_FALL,
    PPP_RISE
  } ppp_cond_t;
  typedef logic [7:0] ppp_byte_t;
  typedef logic [4:0] ppp_stat_t;
endpackage

// [core/ppp_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module ppp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      s1_ff <= asyncIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Change counts only when the last two stages agree
      if (s2_ff == s3_ff) begin
        syncOut <= s3_ff;
      end
    end
  end
endmodule
`default_nettype wire

// [core/ppp_port.sv]
// Parallel printer / general parallel I/O port with register port and interrupt.
// Assumes a single-cycle strobe master on core_clk and asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
`include "ppp_consts.svh"
module ppp_port (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire ppp_pkg::ppp_byte_t dataIn,
  output ppp_pkg::ppp_byte_t dataOut,
  output logic dataOe,
  output logic strobe_n,
  output logic printer_init_out_n,
  input wire logic ackIn,
  input wire logic fault_n_in,
  input wire logic printer_occupied_in,
  input wire logic selectIn,
  input wire logic paper_out_in,
  output logic irq
);
  import ppp_pkg::*;
  localparam logic [5:0] SLOW_CYC = 6'(`PPP_SLOW_CYC);
  localparam logic [5:0] FAST_CYC = 6'(`PPP_FAST_CYC);
  localparam ppp_stat_t STAT_RST = `PPP_RST_STAT;
  localparam ppp_byte_t PIN_RST = `PPP_RST_PINS;

  ppp_byte_t data_ff;
  logic [7:0] ctrl_ff;
  ppp_stat_t irqSt_ff;
  ppp_stat_t irqMsk_ff;
  ppp_cond_t cond_ff [5];
  ppp_stat_t statPrev_ff;
  wire ppp_stat_t statSync;
  ppp_stat_t statRaw;
  wire ppp_byte_t dataSync;
  ppp_stat_t hit;
  logic [5:0] pulseCnt_ff;
  logic pulseBusy;
  logic dataWr;

  assign statRaw = {paper_out_in, selectIn, printer_occupied_in, fault_n_in, ackIn};

  // Synchronisers reset to the idle pin levels, so no false edge follows reset
  ppp_sync #(
    .RST_VAL(STAT_RST[0])
  ) u_syncAck (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(statRaw[0]),
    .syncOut(statSync[0])
  );

  ppp_sync #(
    .RST_VAL(STAT_RST[1])
  ) u_syncFault (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(statRaw[1]),
    .syncOut(statSync[1])
  );

  ppp_sync #(
    .RST_VAL(STAT_RST[2])
  ) u_syncOccupied (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(statRaw[2]),
    .syncOut(statSync[2])
  );

  ppp_sync #(
    .RST_VAL(STAT_RST[3])
  ) u_syncSelect (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(statRaw[3]),
    .syncOut(statSync[3])
  );

  ppp_sync #(
    .RST_VAL(STAT_RST[4])
  ) u_syncPaper (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(statRaw[4]),
    .syncOut(statSync[4])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[0])
  ) u_syncData0 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[0]),
    .syncOut(dataSync[0])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[1])
  ) u_syncData1 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[1]),
    .syncOut(dataSync[1])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[2])
  ) u_syncData2 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[2]),
    .syncOut(dataSync[2])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[3])
  ) u_syncData3 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[3]),
    .syncOut(dataSync[3])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[4])
  ) u_syncData4 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[4]),
    .syncOut(dataSync[4])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[5])
  ) u_syncData5 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[5]),
    .syncOut(dataSync[5])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[6])
  ) u_syncData6 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[6]),
    .syncOut(dataSync[6])
  );

  ppp_sync #(
    .RST_VAL(PIN_RST[7])
  ) u_syncData7 (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(dataIn[7]),
    .syncOut(dataSync[7])
  );

  assign pulseBusy = (pulseCnt_ff != 6'h00);
  // Writes are refused while strobe is low so the byte cannot change under it
  assign dataWr = regWr && (regAddr == `PPP_OFF_DATA) && !pulseBusy && strobe_n;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      data_ff <= `PPP_RST_DATA;
    end else if (dataWr) begin
      data_ff <= regWdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_ff <= `PPP_RST_CTRL;
    end else if (regWr && regAddr == `PPP_OFF_CTRL) begin
      ctrl_ff <= {3'h0, regWdata[4:0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irqMsk_ff <= 5'h00;
    end else if (regWr && regAddr == `PPP_OFF_IRQMSK) begin
      irqMsk_ff <= regWdata[4:0];
    end
  end

  // Two bits per input: inputs 0..3 in the first word, input 4 in the second
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 5; i++) begin
        cond_ff[i] <= PPP_HIGH;
      end
    end else if (regWr && regAddr == `PPP_OFF_COND0) begin
      for (int i = 0; i < 4; i++) begin
        cond_ff[i] <= ppp_cond_t'(regWdata[2*i +: 2]);
      end
    end else if (regWr && regAddr == `PPP_OFF_COND1) begin
      cond_ff[4] <= ppp_cond_t'(regWdata[1:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      statPrev_ff <= STAT_RST;
    end else begin
      statPrev_ff <= statSync;
    end
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      unique case (cond_ff[i])
        PPP_HIGH: hit[i] = statSync[i];
        PPP_LOW: hit[i] = !statSync[i];
        PPP_FALL: hit[i] = statPrev_ff[i] && !statSync[i];
        PPP_RISE: hit[i] = !statPrev_ff[i] && statSync[i];
      endcase
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irqSt_ff <= 5'h00;
    end else if (regWr && regAddr == `PPP_OFF_IRQST) begin
      irqSt_ff <= (irqSt_ff & ~regWdata[4:0]) | hit;
    end else begin
      irqSt_ff <= irqSt_ff | hit;
    end
  end

  assign irq = |(irqSt_ff & irqMsk_ff);

  // Auto pulse starts on an accepted data write; width picked at that moment
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pulseCnt_ff <= 6'h00;
    end else if (dataWr && ctrl_ff[`PPP_CTRL_AUTO]) begin
      pulseCnt_ff <= ctrl_ff[`PPP_CTRL_FAST] ? FAST_CYC : SLOW_CYC;
    end else if (pulseBusy) begin
      pulseCnt_ff <= pulseCnt_ff - 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      strobe_n <= 1'b1;
      printer_init_out_n <= 1'b1;
    end else begin
      if (ctrl_ff[`PPP_CTRL_AUTO]) begin
        strobe_n <= !(pulseBusy || (dataWr));
      end else begin
        strobe_n <= !ctrl_ff[`PPP_CTRL_STRB];
      end
      printer_init_out_n <= !ctrl_ff[`PPP_CTRL_INIT];
    end
  end

  // A single direction bit covers all eight lines
  assign dataOe = ctrl_ff[`PPP_CTRL_DIR];
  assign dataOut = data_ff;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `PPP_OFF_DATA: regRdata <= dataOe ? data_ff : dataSync;
        `PPP_OFF_CTRL: regRdata <= ctrl_ff;
        `PPP_OFF_STAT: regRdata <= {2'h0, pulseBusy, statSync};
        `PPP_OFF_IRQST: regRdata <= {3'h0, irqSt_ff};
        `PPP_OFF_IRQMSK: regRdata <= {3'h0, irqMsk_ff};
        `PPP_OFF_COND0: regRdata <= {cond_ff[3], cond_ff[2], cond_ff[1], cond_ff[0]};
        `PPP_OFF_COND1: regRdata <= {6'h00, cond_ff[4]};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [tb/ppp_port_sva.sv]
// Port checker.
// Assumes the constants header on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "ppp_consts.svh"
module ppp_port_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire ppp_pkg::ppp_byte_t dataOut,
  input wire logic dataOe,
  input wire logic strobe_n,
  input wire logic printer_init_out_n,
  input wire logic irq
);
  import ppp_pkg::*;
  logic [4:0] ctrl_ff;
  logic [7:0] low_ff;
  logic dWr;
  assign dWr = regWr && regAddr == `PPP_OFF_DATA && ctrl_ff[1] && strobe_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Shadow of the control bits, updated as the port takes writes
  always_ff @(posedge core_clk) begin
    if (!nrst) ctrl_ff <= 5'(`PPP_RST_CTRL);
    else if (regWr && regAddr == `PPP_OFF_CTRL) ctrl_ff <= regWdata[4:0];
  end
  always_ff @(posedge core_clk) low_ff <= (!nrst || strobe_n) ? 8'h00 : low_ff + 8'h01;
  property p_init; printer_init_out_n == !$past(ctrl_ff[4]); endproperty
  a_init: assert property (p_init) else $error("init level");
  property p_dir; dataOe == ctrl_ff[0]; endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_man; !ctrl_ff[1] |=> strobe_n == !$past(ctrl_ff[3]); endproperty
  a_man: assert property (p_man) else $error("manual strobe");
  property p_fast; dWr && ctrl_ff[2] |=> !strobe_n [*6] ##1 strobe_n; endproperty
  a_fast: assert property (p_fast) else $error("fast pulse");
  property p_width; $rose(strobe_n) && ctrl_ff[1] |->
    low_ff == (ctrl_ff[2] ? `PPP_FAST_CYC + 1 : `PPP_SLOW_CYC + 1); endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_hold; !strobe_n ##1 !strobe_n |-> $stable(dataOut); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_mask; regWr && regAddr == `PPP_OFF_IRQMSK && regWdata[4:0] == 5'h00 |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_data; dWr && ctrl_ff[0] |=> dataOut == $past(regWdata); endproperty
  a_data: assert property (p_data) else $error("data byte");
endmodule
bind ppp_port ppp_port_chk chk (
  .core_clk(core_clk),
  .nrst(nrst),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr),
  .dataOut(dataOut),
  .dataOe(dataOe),
  .strobe_n(strobe_n),
  .printer_init_out_n(printer_init_out_n),
  .irq(irq)
);
`default_nettype wire

// [tb/ppp_printer.sv]
// Printer model: status lines and byte capture.
// Assumes the bench sets idle status and input byte.
`timescale 1ns/1ns
`default_nettype none
module ppp_printer (
  input wire logic strobe_n,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic [4:0] stSet,
  input wire logic [7:0] drvByte,
  output logic [7:0] dataIn,
  output logic [4:0] stat,
  output logic [7:0] got
);
  assign dataIn = dataOe ? dataOut : drvByte;
  // Occupied while strobe is held, like a real printer
  assign stat = stSet | {2'b00, !strobe_n, 2'b00};
  always @(posedge strobe_n) got = dataOe ? dataOut : ~got;
endmodule
`default_nettype wire

// [tb/ppp_port_test.sv]
// Bench for the parallel port.
// Assumes design, checker and printer model compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "ppp_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module ppp_port_test;
  logic core_clk = 0, nrst = 0, regWr = 0, regRd = 0, dataOe, strobe_n, initN, irq;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, dataIn, dataOut, drvByte = 0, got;
  logic [4:0] stSet = 5'h02, stat;
  int num_errors = 0, comparisons = 0, n;
  ppp_port uut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .strobe_n(strobe_n), .printer_init_out_n(initN), .ackIn(stat[0]),
    .fault_n_in(stat[1]), .printer_occupied_in(stat[2]), .selectIn(stat[3]),
    .paper_out_in(stat[4]), .irq(irq));
  ppp_printer prn (.strobe_n(strobe_n), .dataOut(dataOut), .dataOe(dataOe), .stSet(stSet),
    .drvByte(drvByte), .dataIn(dataIn), .stat(stat), .got(got));
  initial forever #20 core_clk = ~core_clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 0;
    #1 `CHK("read", e, regRdata)
  endtask
  // Second write lands mid-pulse and must be dropped
  task automatic pulse(input logic [7:0] c, input logic [7:0] d, input int len);
    wr(`PPP_OFF_CTRL, c);
    wr(`PPP_OFF_DATA, d);
    n = 0;
    fork
      wr(`PPP_OFF_DATA, ~d);
      repeat (40) begin
        #1 n += int'(!strobe_n);
        @(posedge core_clk);
      end
    join
    `CHK("low cycles", len, n)
    `CHK("printed", d, got)
    rd(`PPP_OFF_DATA, d);
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1;
    rd(`PPP_OFF_CTRL, `PPP_RST_CTRL);
    `CHK("pins", 3'b110, {strobe_n, initN, dataOe})
    rd(8'hfc, 8'h00);
    rd(`PPP_OFF_STAT, 8'h02);
    pulse(8'h03, 8'ha5, `PPP_SLOW_CYC + 1);
    pulse(8'h07, 8'h5a, `PPP_FAST_CYC + 1);
    wr(`PPP_OFF_CTRL, 8'h19);
    @(posedge core_clk);
    #1 `CHK("manual", 2'b00, {strobe_n, initN})
    wr(`PPP_OFF_CTRL, 8'h00);
    drvByte <= 8'h3c;
    repeat (6) @(posedge core_clk);
    rd(`PPP_OFF_DATA, 8'h3c);
    for (int c = 0; c < 4; c++) begin
      stSet <= 5'h02;
      repeat (6) @(posedge core_clk);
      wr(`PPP_OFF_COND0, 8'(c));
      wr(`PPP_OFF_IRQST, 8'h1f);
      wr(`PPP_OFF_IRQMSK, 8'h01);
      stSet <= 5'h03;
      #1 `CHK("irq low", c == 1, irq)
      repeat (6) @(posedge core_clk);
      stSet <= 5'h02;
      #1 `CHK("irq rise", c != 2, irq)
      repeat (6) @(posedge core_clk);
      #1 `CHK("irq fall", 1'b1, irq)
    end
    wr(`PPP_OFF_COND1, 8'h01);
    wr(`PPP_OFF_IRQMSK, 8'h10);
    #1 `CHK("irq paper", 1'b1, irq)
    wr(`PPP_OFF_IRQST, 8'h10);
    rd(`PPP_OFF_IRQST, 8'h13);
    rd(`PPP_OFF_COND1, 8'h01);
    rd(`PPP_OFF_COND0, 8'h03);
    wr(`PPP_OFF_IRQMSK, 8'h00);
    #1 `CHK("masked", 1'b0, irq)
    end_of_test();
  end
endmodule
`default_nettype wire
